/* fcrs_afe_cfg.v */
/*
  Serial configuration of the analog front ends: writes a fixed table
  after reset, then forwards single words from the command decoder.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "fcrs_consts.vh"
module fcrs_afe_cfg (
  input  wire        clk_sys,
  input  wire        reset,
  input  wire        wrValid,
  input  wire [15:0] wrData,
  output reg         busy,
  output reg         cfgDone,
  output reg         afeSclk,
  output reg         afeSdata,
  output reg         afeSenN
);
  reg [15:0] shift_q;
  reg [4:0]  bitCnt_q;
  reg [3:0]  divCnt_q;
  reg [2:0]  initIdx_q;
  reg [15:0] initWord;

  // Power-up table
  always @* begin
    case (initIdx_q[1:0])
      2'h0:    initWord = `FCRS_AFE_INIT0;
      2'h1:    initWord = `FCRS_AFE_INIT1;
      2'h2:    initWord = `FCRS_AFE_INIT2;
      default: initWord = `FCRS_AFE_INIT3;
    endcase
  end

  // Shift MSB first, data changes on falling clock, enable held low
  always @(posedge clk_sys) begin
    if (reset) begin
      shift_q   <= 16'h0000;
      bitCnt_q  <= 5'h00;
      divCnt_q  <= 4'h0;
      initIdx_q <= 3'h0;
      busy      <= 1'b1;
      cfgDone   <= 1'b0;
      afeSclk   <= 1'b0;
      afeSdata  <= 1'b0;
      afeSenN   <= 1'b1;
    end else if (bitCnt_q != 5'h00) begin
      if (divCnt_q == `FCRS_AFE_DIV - 4'h1) begin
        divCnt_q <= 4'h0;
        afeSclk  <= ~afeSclk;
        if (afeSclk) begin
          bitCnt_q <= bitCnt_q - 5'h01;
          afeSdata <= shift_q[15];
          shift_q  <= {shift_q[14:0], 1'b0};
          afeSenN  <= (bitCnt_q == 5'h01);
        end
      end else begin
        divCnt_q <= divCnt_q + 4'h1;
      end
    end else if (initIdx_q < `FCRS_AFE_INIT_N) begin
      shift_q   <= {initWord[14:0], 1'b0};
      afeSdata  <= initWord[15];
      afeSenN   <= 1'b0;
      bitCnt_q  <= 5'h10;
      initIdx_q <= initIdx_q + 3'h1;
    end else if (wrValid && cfgDone) begin
      shift_q  <= {wrData[14:0], 1'b0};
      afeSdata <= wrData[15];
      afeSenN  <= 1'b0;
      bitCnt_q <= 5'h10;
      busy     <= 1'b1;
    end else begin
      busy    <= 1'b0;
      cfgDone <= 1'b1;
    end
  end
endmodule

/* fcrs_buf2.v */
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module fcrs_buf2 #(
  parameter W = 35
) (
  input  wire         clk_sys,
  input  wire         reset,
  input  wire         inValid,
  output wire         inReady,
  input  wire [W-1:0] inData,
  output wire         outValid,
  input  wire         outReady,
  output wire [W-1:0] outData
);
  reg [W-1:0] mem0_q;
  reg [W-1:0] mem1_q;
  reg [1:0]   cnt_q;
  reg         vld_q;
  wire        push;
  wire        pop;

  assign inReady  = (cnt_q != 2'h2);
  assign outValid = vld_q;
  assign outData  = mem0_q;
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // Head entry always in mem0, so the output comes from a flop
  always @(posedge clk_sys) begin
    if (reset) begin
      mem0_q <= {W{1'b0}};
      mem1_q <= {W{1'b0}};
      cnt_q  <= 2'h0;
      vld_q  <= 1'b0;
    end else begin
      // Valid kept in its own flop so the output needs no decode
      vld_q <= !(cnt_q == 2'h0 && !push) &&
               !(cnt_q == 2'h1 && pop && !push);
      if (pop) begin
        mem0_q <= (cnt_q == 2'h2) ? mem1_q : inData;
      end else if (push && cnt_q == 2'h0) begin
        mem0_q <= inData;
      end
      if (push && ((cnt_q == 2'h1 && !pop) || (cnt_q == 2'h2))) begin
        mem1_q <= inData;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

/* fcrs_consts.vh */
/*
  Constants of the fast camera readout sequencer: timing figures in their
  own units, clock rate, phase patterns, command and telemetry codes.
  Assumes it is included by bare name into each design file that needs it.
*/
`ifndef FCRS_CONSTS_VH
`define FCRS_CONSTS_VH

// System clock rate and the printed timing figures
`define FCRS_CLK_HZ        100000000
`define FCRS_REF_MHZ       50
`define FCRS_SEQ_MHZ       40
`define FCRS_PERIOD_MS     2500
`define FCRS_SLOW_PERIOD_MS 25000
`define FCRS_LINE_NS       90000
`define FCRS_RAMP_NS       22500
`define FCRS_REGCLK_NS     250
`define FCRS_PIXRATE_MHZ   4
`define FCRS_READOUT_MS    1500
`define FCRS_INTEG_MS      2300
`define FCRS_LINK_MBPS     100

// Geometry and link counts
`define FCRS_SENSORS       4
`define FCRS_CHANNELS      8
`define FCRS_PIX_BITS      14
`define FCRS_RAMP_STEPS    4
`define FCRS_REF_TIMEOUT   8'h40

// Vertical phase pattern, one entry per ramp step, three phases
`define FCRS_VPH_IDLE      3'h1
`define FCRS_VPH_S0        3'h3
`define FCRS_VPH_S1        3'h2
`define FCRS_VPH_S2        3'h6
`define FCRS_VPH_S3        3'h4

// Command opcodes in bits 15:12 of a command word
`define FCRS_OP_TIMING     4'h1
`define FCRS_OP_ENABLE     4'h2
`define FCRS_OP_AFEWR      4'h3
`define FCRS_OP_HKREQ      4'h4

// Telemetry word types in bits 31:28
`define FCRS_TM_HDR        4'h1
`define FCRS_TM_PIX        4'h2
`define FCRS_TM_HK         4'h3

// Analog front end power-up settings and serial divider
`define FCRS_AFE_INIT_N    4
`define FCRS_AFE_INIT0     16'h0010
`define FCRS_AFE_INIT1     16'h0120
`define FCRS_AFE_INIT2     16'h0230
`define FCRS_AFE_INIT3     16'h0340
`define FCRS_AFE_DIV       4'h4

`endif

/* fcrs_far_model.sv */
/*
  Far side: reference clock and marker source, telemetry sink.
  Assumes the bench seeds the random generator.
*/
`timescale 1ns/1ps
module fcrs_far_model (
  input wire  clk_sys,
  input wire  slow,
  input wire  markReq,
  output reg  refClk,
  output reg  periodMarker,
  output reg  tmReady
);
  reg [4:0] mCnt_q;
  // Free-running reference, phase offset from clk_sys on purpose
  initial begin
    refClk = 1'b0;
    #3;
    forever #80 refClk = ~refClk;
  end
  // Marker pulse of 20 cycles per request; sink stalls in slow mode
  initial begin
    mCnt_q = 5'h00;
    periodMarker = 1'b0;
    tmReady = 1'b1;
  end
  always @(posedge clk_sys) begin
    if (markReq)
      mCnt_q <= 5'h14;
    else if (mCnt_q != 5'h00)
      mCnt_q <= mCnt_q - 5'h01;
    periodMarker <= markReq || mCnt_q > 5'h01;
    tmReady <= !slow || ($urandom % 3 == 0);
  end
endmodule

/* fcrs_monitor.sv */
/*
  Checker on the top ports of the readout sequencer.
  Assumes it is bound to fcrs_top; one clock domain, sync reset.
*/
`timescale 1ns/1ps
module fcrs_monitor #(
  parameter PERIOD_CYC = 20000
) (
  input wire        clk_sys,
  input wire        reset,
  input wire        periodMarker,
  input wire [11:0] vertPhase,
  input wire [3:0]  regClk,
  input wire        pixSample,
  input wire        afeSenN,
  input wire        tmValid,
  input wire        tmReady,
  input wire [31:0] tmData,
  input wire [2:0]  tmLink,
  input wire        hkBackup,
  input wire        seqActive
);
  reg [11:0] vph_q;
  reg [13:0] step_q;
  reg        rc_q;
  reg [7:0]  rcCnt_q;
  reg        sen_q;
  reg [2:0]  cfg_q;
  reg        mark_q;
  reg [31:0] age_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Run-length counters; all saturate so long idle spans never wrap
  always @(posedge clk_sys) begin
    vph_q <= vertPhase;
    rc_q <= regClk[0];
    sen_q <= afeSenN;
    mark_q <= periodMarker;
    if (reset || vertPhase != vph_q)
      step_q <= 14'h0000;
    else if (step_q != 14'h3FFF)
      step_q <= step_q + 14'h0001;
    if (reset)
      rcCnt_q <= 8'hFF;
    else if (regClk[0] && !rc_q)
      rcCnt_q <= 8'h00;
    else if (rcCnt_q != 8'hFF)
      rcCnt_q <= rcCnt_q + 8'h01;
    if (reset)
      cfg_q <= 3'h0;
    else if (afeSenN && !sen_q && cfg_q != 3'h4)
      cfg_q <= cfg_q + 3'h1;
    if (reset || (periodMarker && !mark_q))
      age_q <= 32'h0;
    else if (age_q != 32'hFFFFFFFF)
      age_q <= age_q + 32'h1;
  end
  AST_REGCLK_SAME: assert property (
    regClk == 4'h0 || regClk == 4'hF) else $error("regClk bits differ");
  AST_VPH_SAME: assert property (
    vertPhase == {4{vertPhase[2:0]}}) else $error("sensor phases differ");
  AST_VPH_STEP: assert property (
    vertPhase != vph_q && vph_q != 12'h249 |-> step_q == 14'h08C9)
    else $error("vertical step not 2250 cycles");
  AST_REGCLK_PER: assert property (
    regClk[0] && !rc_q |-> rcCnt_q >= 8'h18)
    else $error("register clock period under 25 cycles");
  AST_PIX_PULSE: assert property (
    pixSample |-> seqActive ##1 !pixSample)
    else $error("pixSample not a single pulse in readout");
  AST_CFG_FIRST: assert property (
    seqActive |-> cfg_q == 3'h4) else $error("readout before front end setup");
  AST_TM_HOLD: assert property (
    tmValid && !tmReady |=> tmValid && $stable(tmData) && $stable(tmLink))
    else $error("telemetry word changed while stalled");
  AST_BKP_LATE: assert property (
    $rose(hkBackup) |-> age_q >= PERIOD_CYC) else $error("backup too early");
  AST_BKP_DUE: assert property (
    age_q == PERIOD_CYC + 64 |-> hkBackup) else $error("backup not taken");
  // Main scenarios reached
  cover property ($rose(seqActive));
  cover property ($rose(hkBackup));
  cover property (tmValid && !tmReady);
endmodule

/* fcrs_tb_top.sv */
/*
  Bench for fcrs_top: commands, one frame, housekeeping and backup.
  Assumes the far-side model supplies reference clock, marker and tmReady.
*/
`timescale 1ns/1ps
`include "fcrs_consts.vh"
module fcrs_tb_top;
  localparam PER = 40000;
  reg          clk_sys = 1'b0;
  reg          reset = 1'b1;
  reg  [111:0] pixIn = 112'h0;
  reg  [11:0]  hkSample = 12'h000;
  reg          cmdValid = 1'b0;
  reg  [15:0]  cmdWord = 16'h0000;
  reg          slow = 1'b0;
  reg          markReq = 1'b0;
  wire         refClk, periodMarker, tmReady, pixSample, afeSclk;
  wire         afeSdata, afeSenN, tmValid, hkBackup, seqActive;
  wire [11:0]  vertPhase;
  wire [3:0]   regClk;
  wire [31:0]  tmData;
  wire [2:0]   tmLink;
  reg  [66:0]  expQ[$];
  reg  [15:0]  afeQ[$];
  reg  [66:0]  e;
  reg  [15:0]  afeSh;
  reg  [127:0] rnd;
  integer      num_errors = 0, n_compared = 0, afeBits = 0, i, r, c, k;
  always #5 clk_sys = ~clk_sys;
  fcrs_far_model FAR (.clk_sys(clk_sys), .slow(slow), .markReq(markReq),
    .refClk(refClk), .periodMarker(periodMarker), .tmReady(tmReady));
  fcrs_top #(.ROWS(2), .COLS(4), .PERIOD_CYC(PER), .INTEG_CYC(1000)) DUT (
    .clk_sys(clk_sys), .reset(reset), .refClk(refClk),
    .periodMarker(periodMarker), .pixIn(pixIn), .hkSample(hkSample),
    .cmdValid(cmdValid), .cmdWord(cmdWord), .tmReady(tmReady),
    .vertPhase(vertPhase), .regClk(regClk), .pixSample(pixSample),
    .afeSclk(afeSclk), .afeSdata(afeSdata), .afeSenN(afeSenN),
    .tmValid(tmValid), .tmData(tmData), .tmLink(tmLink),
    .hkBackup(hkBackup), .seqActive(seqActive));
  task err(input string nm, input [31:0] ex, input [31:0] sn);
    begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk_sys);
  endtask
  task cmd(input [15:0] w);
    begin
      @(posedge clk_sys);
      cmdValid <= 1'b1;
      cmdWord <= w;
      @(posedge clk_sys);
      cmdValid <= 1'b0;
    end
  endtask
  task expw(input [2:0] l, input [31:0] m, input [31:0] d);
    expQ.push_back({l, m, d});
  endtask
  task hkreq(input [3:0] flags);
    begin
      rnd = {$urandom, $urandom, $urandom, $urandom};
      @(posedge clk_sys);
      hkSample <= rnd[11:0];
      cyc(2);
      expw(3'h0, 32'hFFFFFFFF, {`FCRS_TM_HK, flags, 12'h000, rnd[11:0]});
      cmd(16'h4000);
    end
  endtask
  task final_report;
    begin
      if (num_errors == 0 && n_compared > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Each popped telemetry word is matched with the oldest expectation
  always @(posedge clk_sys) begin
    if (tmValid === 1'b1 && tmReady === 1'b1) begin
      n_compared = n_compared + 1;
      if (expQ.size() == 0)
        err("tmData unexpected", 32'h0, tmData);
      else begin
        e = expQ.pop_front();
        if ((tmData & e[63:32]) !== e[31:0] || tmLink !== e[66:64])
          err("tmData", e[31:0], tmData);
      end
    end
  end
  // Front end serial words: MSB first, taken on the rising serial clock
  always @(posedge afeSclk) begin
    if (afeSenN === 1'b0) begin
      afeSh = {afeSh[14:0], afeSdata};
      afeBits = afeBits + 1;
    end
  end
  always @(posedge afeSenN) begin
    if (reset === 1'b0) begin
      n_compared = n_compared + 1;
      if (afeQ.size() == 0 || afeBits != 16)
        err("afe word", 32'h0, afeSh);
      else if (afeSh !== afeQ.pop_front())
        err("afe word", 32'h0, afeSh);
      afeBits = 0;
    end
  end
  // Hang guard, well beyond the expected run length
  initial begin
    cyc(90000);
    err("watchdog", 32'h0, 32'h1);
    final_report;
  end
  initial begin
    void'($urandom(93375));
    afeQ = '{`FCRS_AFE_INIT0, `FCRS_AFE_INIT1, `FCRS_AFE_INIT2,
      `FCRS_AFE_INIT3};
    cyc(5);
    reset <= 1'b0;
    cyc(1000);
    cmd(16'h1001);
    hkreq(4'b0010);
    cmd(16'h1000);
    cmd(16'h7123);
    rnd = {$urandom, $urandom, $urandom, $urandom};
    afeQ.push_back({4'h0, rnd[11:0]});
    cmd({`FCRS_OP_AFEWR, rnd[11:0]});
    cyc(200);
    cmd(16'h2001);
    hkreq(4'b0001);
    cyc(20);
    // One frame with the sink stalling; pixel inputs held steady
    slow <= 1'b1;
    rnd = {$urandom, $urandom, $urandom, $urandom};
    pixIn <= rnd[111:0];
    cyc(5);
    expw(3'h0, 32'hFF000000, {`FCRS_TM_HDR, 28'h0});
    for (r = 0; r < 2; r = r + 1)
      for (c = 0; c < 4; c = c + 1)
        for (k = 0; k < 8; k = k + 1)
          expw(k[2:0], 32'hFFFFFFFF, {`FCRS_TM_PIX, r[11:0], 2'b00,
            pixIn[14*k +: 14]});
    expw(3'h0, 32'hFFFFFFFF, {`FCRS_TM_HK, 4'b0001, 12'h000, hkSample});
    @(posedge clk_sys);
    markReq <= 1'b1;
    @(posedge clk_sys);
    markReq <= 1'b0;
    for (i = 0; i < 20 && seqActive !== 1'b1; i = i + 1)
      @(posedge clk_sys);
    n_compared = n_compared + 1;
    if (seqActive !== 1'b1)
      err("seqActive start", 32'h1, seqActive);
    for (i = 0; i < 60000 && seqActive !== 1'b0; i = i + 1)
      @(posedge clk_sys);
    for (i = 0; i < 3000 && expQ.size() != 0; i = i + 1)
      @(posedge clk_sys);
    if (expQ.size() != 0)
      err("words left", 32'h0, expQ.size());
    // Marker withheld: backup timing must take over and show in HK
    slow <= 1'b0;
    cmd(16'h2000);
    for (i = 0; i < PER + 200 && hkBackup !== 1'b1; i = i + 1)
      @(posedge clk_sys);
    n_compared = n_compared + 1;
    if (hkBackup !== 1'b1)
      err("hkBackup", 32'h1, hkBackup);
    hkreq(4'b1000);
    cyc(100);
    if (expQ.size() != 0)
      err("words left", 32'h0, expQ.size());
    final_report;
  end
endmodule
bind fcrs_top fcrs_monitor #(.PERIOD_CYC(PERIOD_CYC)) u_mon (
  .clk_sys(clk_sys), .reset(reset), .periodMarker(periodMarker),
  .vertPhase(vertPhase), .regClk(regClk), .pixSample(pixSample),
  .afeSenN(afeSenN), .tmValid(tmValid), .tmReady(tmReady),
  .tmData(tmData), .tmLink(tmLink), .hkBackup(hkBackup),
  .seqActive(seqActive));

/* fcrs_top.v */
/*
  Fast camera readout sequencer: clock/sync handling, frame-transfer
  sequencer for four sensors, pixel capture, command decoding and
  telemetry framing toward eight link codecs.
  Assumes external codecs, analog front ends and clock drivers; the
  reference clock and period marker arrive as asynchronous pins.
*/
`timescale 1ns/1ps
`include "fcrs_consts.vh"
module fcrs_top #(
  parameter ROWS        = 2048,
  parameter COLS        = 2560,
  parameter LINE_CYC    = `FCRS_LINE_NS / (1000000000 / `FCRS_CLK_HZ),
  parameter PERIOD_CYC  = `FCRS_PERIOD_MS * (`FCRS_CLK_HZ / 1000),
  parameter INTEG_CYC   = `FCRS_INTEG_MS * (`FCRS_CLK_HZ / 1000)
) (
  input  wire        clk_sys,
  input  wire        reset,
  input  wire        refClk,
  input  wire        periodMarker,
  input  wire [111:0] pixIn,
  input  wire [11:0] hkSample,
  input  wire        cmdValid,
  input  wire [15:0] cmdWord,
  input  wire        tmReady,
  output reg  [11:0] vertPhase,
  output reg  [3:0]  regClk,
  output reg         pixSample,
  output wire        afeSclk,
  output wire        afeSdata,
  output wire        afeSenN,
  output wire        tmValid,
  output wire [31:0] tmData,
  output wire [2:0]  tmLink,
  output reg         hkBackup,
  output reg         seqActive
);
  localparam NS_PER_CYC = 1000000000 / `FCRS_CLK_HZ;
  localparam RAMP_CYC   = `FCRS_RAMP_NS / NS_PER_CYC;
  localparam REG_CYC    = `FCRS_REGCLK_NS / NS_PER_CYC;
  localparam REG_HALF   = REG_CYC / 2;
  localparam S_IDLE  = 3'h0;
  localparam S_FXFER = 3'h1;
  localparam S_LINE  = 3'h2;
  localparam S_READ  = 3'h3;
  localparam S_INTEG = 3'h4;

  reg  [2:0]  state_q;
  reg  [31:0] stepCnt_q;
  reg  [1:0]  rampStep_q;
  reg  [11:0] rowCnt_q;
  reg  [11:0] colCnt_q;
  reg  [4:0]  regCnt_q;
  reg  [31:0] integCnt_q;
  reg         ref1_q, ref2_q, ref3_q;
  reg         mark1_q, mark2_q, mark3_q;
  reg  [7:0]  refAge_q;
  reg  [31:0] missCnt_q;
  reg  [31:0] intCnt_q;
  reg         forceInt_q;
  reg         seqEnable_q;
  reg  [23:0] timeCode_q;
  reg  [111:0] pixS1_q, pixS2_q, pixHold_q;
  reg  [8:0]  pixPend_q;
  reg         hdrPend_q;
  reg         hkPend_q;
  reg  [2:0]  pixIdx_q;
  reg  [2:0]  vph;
  reg         emitValid;
  reg  [34:0] emitData;
  wire        refRise, extMark, refLost, useInt, intMark, startMark;
  wire        bufReady, afeBusy, afeDone, afeWr, regWrap, sampleHold;
  wire [34:0] bufOut;
  wire [13:0] pixSel;

  // Two-flop synchronisers for the reference clock, marker and pixels
  always @(posedge clk_sys) begin
    if (reset) begin
      {ref1_q, ref2_q, ref3_q}    <= 3'h0;
      {mark1_q, mark2_q, mark3_q} <= 3'h0;
      pixS1_q <= {112{1'b0}};
      pixS2_q <= {112{1'b0}};
    end else begin
      ref1_q  <= refClk;
      ref2_q  <= ref1_q;
      ref3_q  <= ref2_q;
      mark1_q <= periodMarker;
      mark2_q <= mark1_q;
      mark3_q <= mark2_q;
      pixS1_q <= pixIn;
      pixS2_q <= pixS1_q;
    end
  end
  assign refRise = ref2_q & ~ref3_q;
  assign extMark = mark2_q & ~mark3_q;

  // Watchdogs: a lost reference or marker falls back to internal timing
  // so the sequencer never stalls waiting on a dead input
  always @(posedge clk_sys) begin
    if (reset) begin
      refAge_q  <= 8'h00;
      missCnt_q <= 32'h0;
      hkBackup  <= 1'b0;
    end else begin
      refAge_q <= refRise ? 8'h00 :
                  (refLost ? refAge_q : refAge_q + 8'h01);
      if (extMark) begin
        missCnt_q <= 32'h0;
        hkBackup  <= 1'b0;
      end else if (missCnt_q > PERIOD_CYC) begin
        hkBackup  <= 1'b1;
      end else begin
        missCnt_q <= missCnt_q + 32'h1;
      end
    end
  end
  assign refLost = (refAge_q == `FCRS_REF_TIMEOUT);
  assign useInt  = forceInt_q | hkBackup | refLost;

  // Internal period generator, restarted by every external marker in external mode for continuity
  always @(posedge clk_sys) begin
    if (reset) begin
      intCnt_q <= 32'h0;
    end else if (startMark || intCnt_q == PERIOD_CYC - 1) begin
      intCnt_q <= 32'h0;
    end else begin
      intCnt_q <= intCnt_q + 32'h1;
    end
  end
  assign intMark   = (intCnt_q == PERIOD_CYC - 1);
  assign startMark = useInt ? intMark : extMark;

  // Command decoder: timing source, enable, front-end writes, HK request
  always @(posedge clk_sys) begin
    if (reset) begin
      forceInt_q  <= 1'b0;
      seqEnable_q <= 1'b0;
    end else if (cmdValid) begin
      if (cmdWord[15:12] == `FCRS_OP_TIMING) begin
        forceInt_q <= cmdWord[0];
      end
      if (cmdWord[15:12] == `FCRS_OP_ENABLE) begin
        seqEnable_q <= cmdWord[0];
      end
    end
  end
  assign afeWr = cmdValid & (cmdWord[15:12] == `FCRS_OP_AFEWR);

  // Register clock counter; in external mode the wrap waits for a
  // reference edge, which may stretch the period by one reference cycle
  assign regWrap    = (regCnt_q == REG_CYC - 1) & (useInt | refRise);
  assign sampleHold = (pixPend_q != 9'h000) | hdrPend_q;
  always @(posedge clk_sys) begin
    if (reset || state_q != S_READ) begin
      regCnt_q <= 5'h00;
    end else if (regCnt_q == REG_CYC - 1) begin
      if (regWrap && !sampleHold) begin
        regCnt_q <= 5'h00;
      end
    end else begin
      regCnt_q <= regCnt_q + 5'h01;
    end
  end

  // Sequencer: frame transfer, then per row a line transfer and readout
  always @(posedge clk_sys) begin
    if (reset) begin
      state_q    <= S_IDLE;
      stepCnt_q  <= 32'h0;
      rampStep_q <= 2'h0;
      rowCnt_q   <= 12'h000;
      colCnt_q   <= 12'h000;
      integCnt_q <= 32'h0;
      timeCode_q <= 24'h000000;
    end else begin
      integCnt_q <= (state_q == S_FXFER) ? 32'h0 :
                    (integCnt_q == INTEG_CYC ? integCnt_q
                                             : integCnt_q + 32'h1);
      if (startMark) begin
        timeCode_q <= timeCode_q + 24'h000001;
      end
      case (state_q)
        S_IDLE, S_INTEG: begin
          if (startMark && seqEnable_q && afeDone &&
              integCnt_q == INTEG_CYC) begin
            state_q    <= S_FXFER;
            stepCnt_q  <= 32'h0;
            rampStep_q <= 2'h0;
            rowCnt_q   <= 12'h000;
          end
        end
        S_FXFER, S_LINE: begin
          if (stepCnt_q == RAMP_CYC - 1) begin
            stepCnt_q  <= 32'h0;
            rampStep_q <= rampStep_q + 2'h1;
            if (rampStep_q == `FCRS_RAMP_STEPS - 1) begin
              if (state_q == S_LINE) begin
                state_q  <= S_READ;
                colCnt_q <= 12'h000;
              end else if (rowCnt_q == ROWS - 1) begin
                state_q  <= S_LINE;
                rowCnt_q <= 12'h000;
              end else begin
                rowCnt_q <= rowCnt_q + 12'h001;
              end
            end
          end else begin
            stepCnt_q <= stepCnt_q + 32'h1;
          end
        end
        S_READ: begin
          if (regWrap && !sampleHold) begin
            colCnt_q <= colCnt_q + 12'h001;
            if (colCnt_q == COLS - 1) begin
              if (rowCnt_q == ROWS - 1) begin
                state_q <= S_INTEG;
              end else begin
                state_q  <= S_LINE;
                rowCnt_q <= rowCnt_q + 12'h001;
              end
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Vertical phase pattern per ramp step
  always @* begin
    case (rampStep_q)
      2'h0:    vph = `FCRS_VPH_S0;
      2'h1:    vph = `FCRS_VPH_S1;
      2'h2:    vph = `FCRS_VPH_S2;
      default: vph = `FCRS_VPH_S3;
    endcase
    if (state_q != S_FXFER && state_q != S_LINE) begin
      vph = `FCRS_VPH_IDLE;
    end
  end

  // Sensor clock outputs: the same waveform to all four sensors
  always @(posedge clk_sys) begin
    if (reset) begin
      vertPhase <= {4{`FCRS_VPH_IDLE}};
      regClk    <= 4'h0;
      pixSample <= 1'b0;
      seqActive <= 1'b0;
    end else begin
      vertPhase <= {4{vph}};
      regClk    <= {4{(state_q == S_READ) && (regCnt_q < REG_HALF)}};
      pixSample <= (state_q == S_READ) && (regCnt_q == REG_HALF);
      seqActive <= (state_q != S_IDLE) && (state_q != S_INTEG);
    end
  end

  // Pixel capture and telemetry emission; pending header and pixel words hold the
  // register clock so that a stalled link loses no pixel
  always @(posedge clk_sys) begin
    if (reset) begin
      pixHold_q <= {112{1'b0}};
      pixPend_q <= 9'h000;
      pixIdx_q  <= 3'h0;
      hdrPend_q <= 1'b0;
      hkPend_q  <= 1'b0;
    end else begin
      if (state_q == S_READ && regCnt_q == REG_HALF) begin
        pixHold_q <= pixS2_q;
        pixPend_q <= 9'h0FF;
        pixIdx_q  <= 3'h0;
      end else if (emitValid && bufReady && !hdrPend_q &&
                   pixPend_q != 9'h000) begin
        pixPend_q <= {1'b0, pixPend_q[8:1]};
        pixIdx_q  <= pixIdx_q + 3'h1;
      end
      if ((state_q != S_FXFER) && (state_q != S_IDLE) &&
          (state_q != S_INTEG)) begin
        hdrPend_q <= hdrPend_q & ~(emitValid & bufReady);
      end else if (state_q == S_FXFER && stepCnt_q == 32'h0 &&
                   rampStep_q == 2'h0 && rowCnt_q == 12'h000) begin
        hdrPend_q <= 1'b1;
      end else begin
        hdrPend_q <= hdrPend_q & ~(emitValid & bufReady);
      end
      if ((cmdValid && cmdWord[15:12] == `FCRS_OP_HKREQ) ||
          (state_q == S_READ && colCnt_q == COLS - 1 &&
           rowCnt_q == ROWS - 1 && regWrap && !sampleHold)) begin
        hkPend_q <= 1'b1;
      end else if (emitValid && bufReady && !hdrPend_q &&
                   pixPend_q == 9'h000) begin
        hkPend_q <= 1'b0;
      end
    end
  end
  assign pixSel = pixHold_q[pixIdx_q * 14 +: 14];

  // Word selection: header, then pixels, then housekeeping
  always @* begin
    emitValid = 1'b0;
    emitData  = 35'h0;
    if (hdrPend_q) begin
      emitValid = 1'b1;
      emitData  = {3'h0, `FCRS_TM_HDR, 4'h0, timeCode_q};
    end else if (pixPend_q != 9'h000) begin
      emitValid = 1'b1;
      emitData  = {pixIdx_q, `FCRS_TM_PIX, rowCnt_q, 2'h0, pixSel};
    end else if (hkPend_q) begin
      emitValid = 1'b1;
      emitData  = {3'h0, `FCRS_TM_HK, hkBackup, refLost, forceInt_q,
                   seqEnable_q, 12'h000, hkSample};
    end
  end

  // Two-entry buffer toward the codecs; link index rides in the top bits
  fcrs_buf2 #(
    .W (35)
  ) uBuf (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .inValid  (emitValid),
    .inReady  (bufReady),
    .inData   (emitData),
    .outValid (tmValid),
    .outReady (tmReady),
    .outData  (bufOut)
  );
  assign tmData = bufOut[31:0];
  assign tmLink = bufOut[34:32];

  // Front-end configuration: power-up table, then decoded writes
  fcrs_afe_cfg uAfe (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .wrValid  (afeWr),
    .wrData   ({4'h0, cmdWord[11:0]}),
    .busy     (afeBusy),
    .cfgDone  (afeDone),
    .afeSclk  (afeSclk),
    .afeSdata (afeSdata),
    .afeSenN  (afeSenN)
  );
endmodule
